// [verilog/pbhh_regs.svh]
// constants and reset values of the primary bus hold handshake
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef PBHH_REGS_SVH
`define PBHH_REGS_SVH
`define PBHH_ADDR_W 24
`define PBHH_DATA_W 32
`define PBHH_WS_W 3
`define PBHH_REQ_EXTRA 3
`define PBHH_GRANT_RST 1'b1
`define PBHH_STROBE_RST 1'b1
`define PBHH_OE_RST 1'b1
`define PBHH_DATA_OE_RST 1'b0
`define PBHH_ACK_RST 1'b0
`define PBHH_RW_RST 1'b1
`endif

// [verilog/pbhh_pkg.sv]
// types of the primary bus hold handshake
package pbhh_pkg;
    typedef enum logic [2:0] {
        PBHH_IDLE,
        PBHH_ACCESS,
        PBHH_HOLD_STROBE,
        PBHH_HELD,
        PBHH_RETURN
    } pbhh_state_e;
endpackage

// [verilog/pbhh_wr_if.sv]
// carrier between the hold controller and its parked-write store
interface pbhh_wr_if #(
    parameter int AW = 24,
    parameter int DW = 32
);
    logic push;
    logic pop;
    logic [AW-1:0] push_addr;
    logic [DW-1:0] push_data;
    logic valid;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    modport owner(output push, output pop, output push_addr, output push_data,
                  input valid, input addr, input data);
    modport store(input push, input pop, input push_addr, input push_data,
                  output valid, output addr, output data);
endinterface

// [verilog/pbhh_wpend.sv]
// one-entry store for a write parked while the bus is released
module pbhh_wpend #(
    parameter int AW = 24,
    parameter int DW = 32
) (
    input wire logic core_clk,
    input wire logic rst_n_sync,
    input wire logic clk_en,
    pbhh_wr_if.store wr
);
    logic valid_ff;
    logic [AW-1:0] addr_ff;
    logic [DW-1:0] data_ff;

    // push wins over pop so a parked write is never lost
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            valid_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr.push) begin
                valid_ff <= 1'b1;
            end else if (wr.pop) begin
                valid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else if (clk_en && wr.push) begin
            addr_ff <= wr.push_addr;
            data_ff <= wr.push_data;
        end
    end

    assign wr.valid = valid_ff;
    assign wr.addr = addr_ff;
    assign wr.data = data_ff;
endmodule

// [verilog/pbhh_top.sv]
// primary bus hold handshake: releases the external bus to another master
`include "pbhh_regs.svh"
module pbhh_top #(
    parameter int AW = `PBHH_ADDR_W,
    parameter int DW = `PBHH_DATA_W,
    parameter int WS_W = `PBHH_WS_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic release_req_n,
    input wire logic ignore_release_control,
    input wire logic [WS_W-1:0] wait_state_count,
    input wire logic core_req_valid,
    input wire logic core_req_write,
    input wire logic [AW-1:0] core_req_addr,
    input wire logic [DW-1:0] core_req_wdata,
    output logic core_ack,
    output logic [DW-1:0] core_rdata,
    output logic bus_release_grant_n,
    output logic access_strobe_n_o,
    output logic access_strobe_oe,
    output logic rw_o,
    output logic rw_oe,
    output logic [AW-1:0] addr_o,
    output logic addr_oe,
    output logic [DW-1:0] data_o,
    output logic data_oe,
    input wire logic [DW-1:0] data_i
);
    //------------------------------------------------------------
    // reset release
    //------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_sync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_sync <= rst_meta_ff;
        end
    end

    //------------------------------------------------------------
    // state and storage
    //------------------------------------------------------------
    pbhh_pkg::pbhh_state_e state_ff;
    pbhh_pkg::pbhh_state_e nxt_state;
    logic req_q_ff;
    logic [WS_W-1:0] wcnt_ff;
    logic from_core_ff;
    logic core_ack_ff;
    logic [DW-1:0] core_rdata_ff;
    logic grant_n_ff;
    logic strobe_n_ff;
    logic strobe_oe_ff;
    logic rw_ff;
    logic rw_oe_ff;
    logic [AW-1:0] addr_ff;
    logic addr_oe_ff;
    logic [DW-1:0] data_ff;
    logic data_oe_ff;
    logic hold_req;
    logic take;
    logic start_pend;
    logic start_core;
    logic park;
    logic access_done;
    logic in_hold;

    pbhh_wr_if #(.AW(AW), .DW(DW)) wr_if ();

    pbhh_wpend #(.AW(AW), .DW(DW)) u_wpend (
        .core_clk(core_clk),
        .rst_n_sync(rst_n_sync),
        .clk_en(clk_en),
        .wr(wr_if.store)
    );

    //------------------------------------------------------------
    // request sampling
    //------------------------------------------------------------
    // one sampling flop: a request missing this edge lands one cycle later
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            req_q_ff <= 1'b0;
        end else if (clk_en) begin
            req_q_ff <= !release_req_n;
        end
    end

    assign hold_req = req_q_ff && !ignore_release_control;
    assign take = core_req_valid && !core_ack_ff;
    assign in_hold = (state_ff == pbhh_pkg::PBHH_HOLD_STROBE) ||
                     (state_ff == pbhh_pkg::PBHH_HELD) ||
                     (state_ff == pbhh_pkg::PBHH_RETURN);
    // hold wins over new accesses; a parked write drains before the core
    assign start_pend = (state_ff == pbhh_pkg::PBHH_IDLE) && !hold_req && wr_if.valid;
    assign start_core = (state_ff == pbhh_pkg::PBHH_IDLE) && !hold_req && !wr_if.valid &&
                        take;
    // only one write may wait; a second write or any read stalls
    assign park = hold_req && take && core_req_write && !wr_if.valid &&
                  (state_ff != pbhh_pkg::PBHH_ACCESS);
    assign access_done = (state_ff == pbhh_pkg::PBHH_ACCESS) && (wcnt_ff == '0);
    assign wr_if.push = park;
    assign wr_if.pop = start_pend;
    assign wr_if.push_addr = core_req_addr;
    assign wr_if.push_data = core_req_wdata;

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pbhh_pkg::PBHH_IDLE: begin
                if (hold_req) begin
                    nxt_state = pbhh_pkg::PBHH_HOLD_STROBE;
                end else if (start_pend || start_core) begin
                    nxt_state = pbhh_pkg::PBHH_ACCESS;
                end
            end
            pbhh_pkg::PBHH_ACCESS: begin
                if (wcnt_ff == '0) begin
                    nxt_state = pbhh_pkg::PBHH_IDLE;
                end
            end
            pbhh_pkg::PBHH_HOLD_STROBE: begin
                if (ignore_release_control) begin
                    nxt_state = pbhh_pkg::PBHH_IDLE;
                end else begin
                    nxt_state = pbhh_pkg::PBHH_HELD;
                end
            end
            pbhh_pkg::PBHH_HELD: begin
                if (ignore_release_control) begin
                    nxt_state = pbhh_pkg::PBHH_IDLE;
                end else if (!req_q_ff) begin
                    nxt_state = pbhh_pkg::PBHH_RETURN;
                end
            end
            pbhh_pkg::PBHH_RETURN: begin
                nxt_state = pbhh_pkg::PBHH_IDLE;
            end
            default: begin
                nxt_state = pbhh_pkg::PBHH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_ff <= pbhh_pkg::PBHH_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    //------------------------------------------------------------
    // access engine
    //------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wcnt_ff <= '0;
            from_core_ff <= 1'b0;
            rw_ff <= `PBHH_RW_RST;
            addr_ff <= '0;
            data_ff <= '0;
        end else if (clk_en) begin
            if (start_pend) begin
                wcnt_ff <= wait_state_count;
                from_core_ff <= 1'b0;
                rw_ff <= 1'b0;
                addr_ff <= wr_if.addr;
                data_ff <= wr_if.data;
            end else if (start_core) begin
                wcnt_ff <= wait_state_count;
                from_core_ff <= 1'b1;
                rw_ff <= !core_req_write;
                addr_ff <= core_req_addr;
                data_ff <= core_req_wdata;
            end else if ((state_ff == pbhh_pkg::PBHH_ACCESS) && (wcnt_ff != '0)) begin
                wcnt_ff <= wcnt_ff - 1'b1;
            end
        end
    end

    // ack for a finished core access or a parked write
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            core_ack_ff <= `PBHH_ACK_RST;
            core_rdata_ff <= '0;
        end else if (clk_en) begin
            core_ack_ff <= park || (access_done && from_core_ff);
            if (access_done && from_core_ff && rw_ff) begin
                core_rdata_ff <= data_i;
            end
        end
    end

    //------------------------------------------------------------
    // pin drivers
    //------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            grant_n_ff <= `PBHH_GRANT_RST;
            strobe_n_ff <= `PBHH_STROBE_RST;
            strobe_oe_ff <= `PBHH_OE_RST;
            rw_oe_ff <= `PBHH_OE_RST;
            addr_oe_ff <= `PBHH_OE_RST;
            data_oe_ff <= `PBHH_DATA_OE_RST;
        end else if (clk_en) begin
            grant_n_ff <= !((nxt_state == pbhh_pkg::PBHH_HELD) ||
                            (nxt_state == pbhh_pkg::PBHH_RETURN));
            strobe_n_ff <= !(nxt_state == pbhh_pkg::PBHH_ACCESS);
            strobe_oe_ff <= !((nxt_state == pbhh_pkg::PBHH_HELD) ||
                              (nxt_state == pbhh_pkg::PBHH_RETURN));
            rw_oe_ff <= !((nxt_state == pbhh_pkg::PBHH_HOLD_STROBE) ||
                          (nxt_state == pbhh_pkg::PBHH_HELD) ||
                          (nxt_state == pbhh_pkg::PBHH_RETURN));
            addr_oe_ff <= !((nxt_state == pbhh_pkg::PBHH_HOLD_STROBE) ||
                            (nxt_state == pbhh_pkg::PBHH_HELD) ||
                            (nxt_state == pbhh_pkg::PBHH_RETURN));
            // data only driven during a write access, so hold always floats it
            data_oe_ff <= (nxt_state == pbhh_pkg::PBHH_ACCESS) &&
                          (start_pend || (start_core && core_req_write) ||
                           ((state_ff == pbhh_pkg::PBHH_ACCESS) && !rw_ff));
        end
    end

    assign core_ack = core_ack_ff;
    assign core_rdata = core_rdata_ff;
    assign bus_release_grant_n = grant_n_ff;
    assign access_strobe_n_o = strobe_n_ff;
    assign access_strobe_oe = strobe_oe_ff;
    assign rw_o = rw_ff;
    assign rw_oe = rw_oe_ff;
    assign addr_o = addr_ff;
    assign addr_oe = addr_oe_ff;
    assign data_o = data_ff;
    assign data_oe = data_oe_ff;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n_sync);

    a_req_to_hold: assert property (
        (state_ff == pbhh_pkg::PBHH_IDLE) && hold_req && clk_en
        |=> state_ff == pbhh_pkg::PBHH_HOLD_STROBE)
        else $error("sampled request did not start hold");
    a_ignore_exits: assert property (
        ignore_release_control && clk_en && state_ff != pbhh_pkg::PBHH_RETURN
        |=> grant_n_ff && state_ff != pbhh_pkg::PBHH_HELD)
        else $error("hold kept while ignore bit set");
    a_no_access_req: assert property (
        hold_req && (state_ff == pbhh_pkg::PBHH_IDLE) && clk_en
        |=> strobe_n_ff)
        else $error("access started while release requested");
    a_one_parked: assert property (
        in_hold && wr_if.valid && clk_en |=> !core_ack_ff)
        else $error("second write accepted while released");
    a_grant_tail: assert property (
        (state_ff == pbhh_pkg::PBHH_HELD) && !req_q_ff && !ignore_release_control && clk_en
        |=> !grant_n_ff ##1 (!clk_en || grant_n_ff))
        else $error("grant not held one cycle after request");
    a_strobe_high_first: assert property (
        $fell(grant_n_ff) |-> $past(strobe_oe_ff) && $past(strobe_n_ff) && !strobe_oe_ff)
        else $error("strobe not driven high before float");
    a_addr_float: assert property (
        !grant_n_ff |-> !addr_oe_ff && !rw_oe_ff)
        else $error("address or rw driven during hold");
    a_data_float: assert property (
        (state_ff == pbhh_pkg::PBHH_HOLD_STROBE) |-> !data_oe_ff)
        else $error("data driven on entering hold");
    a_grant_after_acc: assert property (
        $fell(grant_n_ff) |-> $past(state_ff, 2) != pbhh_pkg::PBHH_ACCESS || !clk_en)
        else $error("grant cut an access short");
    a_access_owns_bus: assert property (
        (state_ff == pbhh_pkg::PBHH_ACCESS) |-> grant_n_ff && strobe_oe_ff && addr_oe_ff)
        else $error("access ran while bus released");
endmodule

// [tb/pbhh_req_model.sv]
// outside bus master that asks for the primary bus
module pbhh_req_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [2:0] wait_state_count,
    input wire logic bus_release_grant_n,
    output logic release_req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int held = 0;
    int granted = 0;
    initial release_req_n = 1'b1;
    // withdrawing early would leave the grant pulse too short to trust
    always @(posedge core_clk) begin
        if (release_req_n) begin
            if (go) begin
                release_req_n <= 1'b0;
                held = 0;
                granted = 0;
            end
        end else begin
            held++;
            if (bus_release_grant_n === 1'b0) granted++;
            if (!go && held >= wait_state_count + 3 && granted >= 2) begin
                release_req_n <= 1'b1;
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// self-checking testbench of the primary bus hold handshake
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    //------------------------------------------------------------
    // signals
    //------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic ce = 1'b1;
    logic ignore_release_control = 1'b0;
    logic [2:0] ws = 3'h0;
    logic vld = 1'b0;
    logic wr = 1'b0;
    logic [23:0] adr = 24'h00_0000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] junk = 32'h0f0f_0f0f;
    logic ack, gnt_n, s_n, s_oe, rw, rw_oe, a_oe, d_oe, req_n;
    logic [23:0] a_o;
    logic [31:0] rd, d_o, d_i;
    int fail_count = 0;
    int cmp_count = 0;
    int low_cnt = 0;
    logic was_low = 1'b0;
    logic prev_soe = 1'b1;
    logic prev_sn = 1'b1;
    logic prev_g = 1'b1;
    logic [23:0] wa_q[$];
    logic [31:0] wd_q[$];

    always #25 core_clk = ~core_clk;

    pbhh_top uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce), .release_req_n(req_n),
        .ignore_release_control(ignore_release_control), .wait_state_count(ws),
        .core_req_valid(vld), .core_req_write(wr), .core_req_addr(adr), .core_req_wdata(wd),
        .core_ack(ack), .core_rdata(rd), .bus_release_grant_n(gnt_n), .access_strobe_n_o(s_n),
        .access_strobe_oe(s_oe), .rw_o(rw), .rw_oe(rw_oe), .addr_o(a_o), .addr_oe(a_oe),
        .data_o(d_o), .data_oe(d_oe), .data_i(d_i));

    pbhh_req_model u_req (.core_clk(core_clk), .go(go), .wait_state_count(ws),
        .bus_release_grant_n(gnt_n), .release_req_n(req_n));

    //------------------------------------------------------------
    // bus memory and wire monitor
    //------------------------------------------------------------
    // an undriven data bus shows a moving pattern, never the last word
    assign d_i = (s_oe && !s_n && rw) ? {8'h5a, a_o} : junk;
    always @(posedge core_clk) junk <= ~junk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge core_clk) begin
        if (rst_n) begin
            if (s_oe && !s_n) begin
                low_cnt++;
                if (!was_low && !rw) begin
                    wa_q.push_back(a_o);
                    wd_q.push_back(d_o);
                    check(d_oe, 1'b1);
                end
            end
            if (!gnt_n) check({s_oe, rw_oe, a_oe, d_oe}, 4'h0);
            if (prev_soe && !s_oe) check(prev_sn, 1'b1);
            if (!prev_g && gnt_n) check({s_oe, rw_oe, a_oe}, 3'h7);
        end
        was_low = s_oe && !s_n;
        prev_soe = s_oe;
        prev_sn = s_n;
        prev_g = gnt_n;
    end

    //------------------------------------------------------------
    // tasks and scenarios
    //------------------------------------------------------------
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_ack(input int lim, output bit got);
        got = 0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge core_clk);
            #1;
            got = (ack === 1'b1);
        end
        if (got && !wr) check(rd, {8'h5a, adr});
        if (got) begin
            @(posedge core_clk);
            vld <= 1'b0;
        end
    endtask

    task automatic core_op(input logic w, input logic [23:0] a, input int lim, output bit got);
        @(posedge core_clk);
        vld <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= {8'ha5, a};
        wait_ack(lim, got);
    endtask

    task automatic wait_g(input logic lvl, input int lim);
        for (int n = 0; n < lim && gnt_n !== lvl; n++) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic take_bus(input int lim);
        go <= 1'b1;
        wait_g(1'b0, lim);
        check(gnt_n, 1'b0);
    endtask

    task automatic release_bus();
        go <= 1'b0;
        for (int i = 0; i < 20 && req_n !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
        check(gnt_n, 1'b0);
        wait_g(1'b1, 3);
        check(gnt_n, 1'b1);
    endtask

    task automatic t_access();
        bit got;
        for (int w = 0; w < 8; w += 7) begin
            @(posedge core_clk);
            ws <= w[2:0];
            low_cnt = 0;
            core_op(1'b0, {21'h0_1234, w[2:0]}, w + 4, got);
            check(got, 1'b1);
            check(low_cnt, w + 1);
            core_op(1'b1, {21'h1_0abc, w[2:0]}, w + 4, got);
            check(got, 1'b1);
            check(wa_q.pop_front(), {21'h1_0abc, w[2:0]});
            check(wd_q.pop_front(), {8'ha5, 21'h1_0abc, w[2:0]});
        end
    endtask

    task automatic t_plain();
        take_bus(4);
        release_bus();
    endtask

    task automatic t_mid();
        bit got;
        @(posedge core_clk);
        ws <= 3'h7;
        @(posedge core_clk);
        vld <= 1'b1;
        wr <= 1'b0;
        adr <= 24'h00_0777;
        for (int i = 0; i < 6 && !(s_oe && !s_n); i++) begin
            @(posedge core_clk);
            #1;
        end
        go <= 1'b1;
        wait_ack(12, got);
        check(got, 1'b1);
        take_bus(4);
        release_bus();
    endtask

    task automatic t_park();
        bit got;
        @(posedge core_clk);
        ws <= 3'h1;
        wa_q.delete();
        wd_q.delete();
        take_bus(4);
        low_cnt = 0;
        core_op(1'b1, 24'h00_0a0a, 3, got);
        check(got, 1'b1);
        core_op(1'b1, 24'h00_0b0b, 10, got);
        check(got, 1'b0);
        check(low_cnt, 0);
        release_bus();
        wait_ack(15, got);
        check(got, 1'b1);
        check(wa_q.size(), 2);
        check(wa_q[0], 24'h00_0a0a);
        check(wd_q[0], 32'ha500_0a0a);
        check(wa_q[1], 24'h00_0b0b);
    endtask

    task automatic t_ignore();
        bit got;
        ws <= 3'h0;
        take_bus(4);
        @(posedge core_clk);
        ignore_release_control <= 1'b1;
        wait_g(1'b1, 3);
        check(gnt_n, 1'b1);
        core_op(1'b0, 24'h00_0c0c, 4, got);
        check(got, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            check(gnt_n, 1'b1);
        end
        @(posedge core_clk);
        ignore_release_control <= 1'b0;
        wait_g(1'b0, 5);
        check(gnt_n, 1'b0);
        release_bus();
    endtask

    // a frozen block must not even sample the request
    task automatic t_freeze();
        @(posedge core_clk);
        ce <= 1'b0;
        go <= 1'b1;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            check(gnt_n, 1'b1);
        end
        @(posedge core_clk);
        ce <= 1'b1;
        wait_g(1'b0, 4);
        check(gnt_n, 1'b0);
        release_bus();
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check({gnt_n, s_n, s_oe, d_oe, ack}, 5'h1c);
        t_access();
        t_plain();
        t_mid();
        t_park();
        t_ignore();
        t_freeze();
        final_report();
    end

    // the tests need well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
endmodule
